// ===== hdl/chain_pkg.sv
// Constants for the command-chaining packet controller
// Function
// - Set receive_inhibit when stored; mask gates interrupt
// - Enable-receive clears receive_inhibit, selects page
// - Long packet when byte 2 is zero
// - Layout: ids, count byte, long count byte
// - Store bytes exactly as transmitter arranges
// - Reset to non-chaining; config bit 6 chains
// - Two transmit, two receive commands and events
// - Done edges set only by completions
// - First enable-transmit clears available and ack
// - Second enable-transmit stored with its page
// - Completion sets done edge, interrupt, ack flag
// - Only clear-transmit command clears its event
// - Second interrupt waits; 200 ns inactive gap
// - Ack flag double-buffered, never interrupts
// - Next token starts stored second transmission
// - After clear, report second transmission result
// - Chaining masks gate only done edges
// - Disable-transmitter cancels oldest queued transmission
// - Receive event held until clear-receive command
// - Second receive page takes next packet
// - Disable-receiver cancels oldest unless started
package chain_pkg;

	// --------------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------------
	localparam logic [7:0] CONFIG_ADDR = 8'h00;
	localparam logic [7:0] MASK_ADDR = 8'h04;
	localparam logic [7:0] COMMAND_ADDR = 8'h08;
	localparam logic [7:0] STATUS_ADDR = 8'h0C;

	// --------------------------------------------------------------------
	// Field positions
	// --------------------------------------------------------------------
	localparam int CFG_LONG_BIT = 3;
	localparam int CFG_CHAIN_BIT = 6;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam int MASK_TX_BIT = 0;
	localparam int MASK_RX_BIT = 1;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam int CMD_PAGE_LSB = 8;
	localparam int STS_TA_BIT = 0;
	localparam int STS_TMA_BIT = 1;
	localparam int STS_TTA_BIT = 2;
	localparam int STS_TRI_BIT = 3;
	localparam int STS_RI_BIT = 4;
	localparam int STS_LONG_BIT = 5;
	localparam int STS_CHAIN_BIT = 6;

	// --------------------------------------------------------------------
	// Command codes
	// --------------------------------------------------------------------
	localparam logic [3:0] CMD_ENABLE_TX = 4'h1;
	localparam logic [3:0] CMD_ENABLE_RX = 4'h2;
	localparam logic [3:0] CMD_DISABLE_TX = 4'h3;
	localparam logic [3:0] CMD_DISABLE_RX = 4'h4;
	localparam logic [3:0] CMD_CLEAR_TX = 4'h5;
	localparam logic [3:0] CMD_CLEAR_RX = 4'h6;

	// --------------------------------------------------------------------
	// Buffer layout and timing
	// --------------------------------------------------------------------
	localparam logic [8:0] SRC_ID_POS = 9'h000;
	localparam logic [8:0] DST_ID_POS = 9'h001;
	localparam logic [8:0] COUNT_POS = 9'h002;
	localparam logic [8:0] LONG_COUNT_POS = 9'h003;
	localparam int CLK_PERIOD_PS = 8000;
	localparam int IRQ_GAP_NS = 200;
	localparam int IRQ_GAP_CYCLES = (IRQ_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [2:0]
	{
		RX_IDLE = 3'b001,
		RX_HEAD = 3'b010,
		RX_DATA = 3'b100
	} rx_state_t;

endpackage

// ===== hdl/packet_command_chaining.sv
// Command queueing, completion status and receive storage for the packet controller
//
// Register access over AHB-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps

module packet_command_chaining #(
	parameter int PAGE_BITS = 3
)
(
	// AHB-Lite slave
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Network core, transmit side
	input wire logic token_seen,
	input wire logic tx_complete,
	input wire logic tx_acked,
	output logic tx_go,
	output logic [PAGE_BITS-1:0] tx_page,
	output logic tx_cancel,
	// Network core, receive side
	input wire logic rx_frame_start,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_frame_end,
	output logic rx_enabled,
	output logic ram_we,
	output logic [PAGE_BITS+7:0] ram_addr,
	output logic [7:0] ram_wdata,
	// Host interrupt
	output logic irq
);

	// --------------------------------------------------------------------
	// Bus slave
	// --------------------------------------------------------------------
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [7:0] config_q;
	logic [1:0] mask_q;
	logic [31:0] status_w;
	wire addr_phase = hsel && hready && htrans[1];
	wire wr_cfg = wr_pend_q && (wr_addr_q == chain_pkg::CONFIG_ADDR);
	wire wr_mask = wr_pend_q && (wr_addr_q == chain_pkg::MASK_ADDR);
	wire wr_cmd = wr_pend_q && (wr_addr_q == chain_pkg::COMMAND_ADDR);
	wire [3:0] cmd_code = hwdata[3:0];
	wire [PAGE_BITS-1:0] cmd_page = hwdata[chain_pkg::CMD_PAGE_LSB +: PAGE_BITS];
	wire chain_on = config_q[chain_pkg::CFG_CHAIN_BIT];
	wire long_on = config_q[chain_pkg::CFG_LONG_BIT];
	wire do_en_tx = wr_cmd && (cmd_code == chain_pkg::CMD_ENABLE_TX);
	wire do_en_rx = wr_cmd && (cmd_code == chain_pkg::CMD_ENABLE_RX);
	wire do_dis_tx = wr_cmd && (cmd_code == chain_pkg::CMD_DISABLE_TX);
	wire do_dis_rx = wr_cmd && (cmd_code == chain_pkg::CMD_DISABLE_RX);
	wire do_clr_tx = wr_cmd && (cmd_code == chain_pkg::CMD_CLEAR_TX);
	wire do_clr_rx = wr_cmd && (cmd_code == chain_pkg::CMD_CLEAR_RX);

	// Read mux, unmapped addresses read zero
	always_comb
	begin
		rdata_d = 32'h00000000;
		case (haddr[7:0])
			chain_pkg::CONFIG_ADDR: rdata_d = {24'h000000, config_q};
			chain_pkg::MASK_ADDR: rdata_d = {30'h00000000, mask_q};
			chain_pkg::STATUS_ADDR: rdata_d = status_w;
			default: rdata_d = 32'h00000000;
		endcase
	end

	// Address phase capture; zero-wait OKAY answers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			rdata_q <= 32'h00000000;
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend_q <= addr_phase && hwrite;
			wr_addr_q <= haddr[7:0];
			if (addr_phase && !hwrite)
				rdata_q <= rdata_d;
		end
	end
	assign hrdata = rdata_q;

	// Configuration and mask registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			config_q <= chain_pkg::CONFIG_RESET;
			mask_q <= chain_pkg::MASK_RESET;
		end
		else
		begin
			if (wr_cfg)
				config_q <= hwdata[7:0];
			if (wr_mask)
				mask_q <= hwdata[1:0];
		end
	end

	// --------------------------------------------------------------------
	// Transmit command queue
	// --------------------------------------------------------------------
	logic [1:0] txq_n_q;
	logic [PAGE_BITS-1:0] txq_pg_q [2];
	logic tx_busy_q;
	logic tx_go_q;
	logic tx_cancel_q;
	wire tx_depth_ok = chain_on ? (txq_n_q < 2'd2) : (txq_n_q == 2'd0);
	wire tx_push = do_en_tx && tx_depth_ok;
	wire tx_launch = token_seen && (txq_n_q != 2'd0) && !tx_busy_q;
	wire tx_finish = tx_complete && tx_busy_q;
	wire tx_drop = do_dis_tx && (txq_n_q != 2'd0) && !tx_finish;
	wire tx_pop = tx_finish || tx_drop;

	// Oldest entry at slot 0, second command kept with its page
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			txq_n_q <= 2'd0;
			txq_pg_q[0] <= '0;
			txq_pg_q[1] <= '0;
			tx_busy_q <= 1'b0;
			tx_go_q <= 1'b0;
			tx_cancel_q <= 1'b0;
		end
		else
		begin
			tx_go_q <= tx_launch && !tx_drop;
			tx_cancel_q <= tx_drop && tx_busy_q;
			if (tx_pop)
				txq_pg_q[0] <= txq_pg_q[1];
			if (tx_push)
				txq_pg_q[(tx_pop ? txq_n_q - 2'd1 : txq_n_q) == 2'd0 ? 0 : 1] <= cmd_page;
			txq_n_q <= txq_n_q + {1'b0, tx_push} - {1'b0, tx_pop};
			if (tx_pop)
				tx_busy_q <= 1'b0;
			else if (tx_launch)
				tx_busy_q <= 1'b1;
		end
	end
	assign tx_go = tx_go_q;
	assign tx_page = txq_pg_q[0];
	assign tx_cancel = tx_cancel_q;

	// --------------------------------------------------------------------
	// Receive command queue
	// --------------------------------------------------------------------
	logic [1:0] rxq_n_q;
	logic [PAGE_BITS-1:0] rxq_pg_q [2];
	logic rx_started_q;
	logic rx_en_q;
	wire rx_depth_ok = chain_on ? (rxq_n_q < 2'd2) : (rxq_n_q == 2'd0);
	wire rx_push = do_en_rx && rx_depth_ok;
	wire rx_begin = rx_frame_start && (rxq_n_q != 2'd0);
	wire rx_finish = rx_frame_end && rx_started_q;
	wire rx_drop = do_dis_rx && (rxq_n_q != 2'd0) && !rx_started_q && !rx_begin;
	wire rx_pop = rx_finish || rx_drop;
	wire [1:0] rxq_n_d = rxq_n_q + {1'b0, rx_push} - {1'b0, rx_pop};

	// Next packet lands in the oldest enabled page
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rxq_n_q <= 2'd0;
			rxq_pg_q[0] <= '0;
			rxq_pg_q[1] <= '0;
			rx_started_q <= 1'b0;
			rx_en_q <= 1'b0;
		end
		else
		begin
			if (rx_pop)
				rxq_pg_q[0] <= rxq_pg_q[1];
			if (rx_push)
				rxq_pg_q[(rx_pop ? rxq_n_q - 2'd1 : rxq_n_q) == 2'd0 ? 0 : 1] <= cmd_page;
			rxq_n_q <= rxq_n_d;
			rx_en_q <= (rxq_n_d != 2'd0);
			if (rx_finish)
				rx_started_q <= 1'b0;
			else if (rx_begin)
				rx_started_q <= 1'b1;
		end
	end
	assign rx_enabled = rx_en_q;

	// --------------------------------------------------------------------
	// Receive buffer write, transmitter byte order kept
	// --------------------------------------------------------------------
	chain_pkg::rx_state_t rx_st_q;
	logic [8:0] rx_pos_q;
	logic [8:0] rx_ptr_q;
	logic rx_long_q;
	logic ram_we_q;
	logic [PAGE_BITS+7:0] ram_addr_q;
	logic [7:0] ram_wdata_q;
	wire [PAGE_BITS+7:0] rx_base = {rxq_pg_q[0], 8'h00};
	wire in_head = (rx_st_q == chain_pkg::RX_HEAD);
	wire is_len = in_head && (rx_pos_q == chain_pkg::COUNT_POS);
	wire is_long_len = in_head && rx_long_q && (rx_pos_q == chain_pkg::LONG_COUNT_POS);
	wire [8:0] rx_off = in_head ? rx_pos_q : rx_ptr_q;
	wire [PAGE_BITS+7:0] rx_waddr = rx_base + {{(PAGE_BITS-1){1'b0}}, rx_off};

	// Header bytes at fixed offsets, data from the count offset on
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rx_st_q <= chain_pkg::RX_IDLE;
			rx_pos_q <= 9'h000;
			rx_ptr_q <= 9'h000;
			rx_long_q <= 1'b0;
			ram_we_q <= 1'b0;
			ram_addr_q <= '0;
			ram_wdata_q <= 8'h00;
		end
		else
		begin
			ram_we_q <= 1'b0;
			case (rx_st_q)
				chain_pkg::RX_IDLE:
				begin
					rx_pos_q <= chain_pkg::SRC_ID_POS;
					rx_long_q <= 1'b0;
					if (rx_begin)
						rx_st_q <= chain_pkg::RX_HEAD;
				end
				chain_pkg::RX_HEAD, chain_pkg::RX_DATA:
				begin
					if (rx_byte_valid)
					begin
						ram_we_q <= 1'b1;
						ram_addr_q <= rx_waddr;
						ram_wdata_q <= rx_byte;
						rx_pos_q <= rx_pos_q + 9'h001;
						if (is_len && long_on && (rx_byte == 8'h00))
							rx_long_q <= 1'b1;
						else if (is_len || is_long_len)
						begin
							rx_ptr_q <= {1'b0, rx_byte};
							rx_st_q <= chain_pkg::RX_DATA;
						end
						else if (!in_head)
							rx_ptr_q <= rx_ptr_q + 9'h001;
					end
					if (rx_frame_end)
						rx_st_q <= chain_pkg::RX_IDLE;
				end
				default: rx_st_q <= chain_pkg::RX_IDLE;
			endcase
		end
	end
	assign ram_we = ram_we_q;
	assign ram_addr = ram_addr_q;
	assign ram_wdata = ram_wdata_q;

	// --------------------------------------------------------------------
	// Completion events, two deep per direction
	// --------------------------------------------------------------------
	logic [1:0] txe_n_q;
	logic [1:0] txe_ack_q;
	logic [1:0] rxe_n_q;
	logic [1:0] rxe_long_q;
	logic last_ack_q;
	logic [7:0] gap_q;
	wire txe_pop = do_clr_tx && (txe_n_q != 2'd0);
	wire rxe_pop = do_clr_rx && (rxe_n_q != 2'd0);
	wire txe_push = tx_finish && (txe_n_q != 2'd2 || txe_pop);
	wire rxe_push = rx_finish && (rxe_n_q != 2'd2 || rxe_pop);
	wire [1:0] txe_slot = txe_pop ? txe_n_q - 2'd1 : txe_n_q;
	wire [1:0] rxe_slot = rxe_pop ? rxe_n_q - 2'd1 : rxe_n_q;

	// Push and pop in one cycle both take effect; a completion is lost only when both slots are full and no clear arrives that cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			txe_n_q <= 2'd0;
			txe_ack_q <= 2'b00;
			rxe_n_q <= 2'd0;
			rxe_long_q <= 2'b00;
			last_ack_q <= 1'b0;
			gap_q <= 8'h00;
		end
		else
		begin
			if (txe_pop)
				txe_ack_q[0] <= txe_ack_q[1];
			if (txe_push)
				txe_ack_q[txe_slot[0]] <= tx_acked;
			txe_n_q <= txe_n_q + {1'b0, txe_push} - {1'b0, txe_pop};
			if (rxe_pop)
				rxe_long_q[0] <= rxe_long_q[1];
			if (rxe_push)
				rxe_long_q[rxe_slot[0]] <= rx_long_q;
			rxe_n_q <= rxe_n_q + {1'b0, rxe_push} - {1'b0, rxe_pop};
			if (tx_push && txq_n_q == 2'd0)
				last_ack_q <= 1'b0;
			else if (tx_finish)
				last_ack_q <= tx_acked;
			if (txe_pop || rxe_pop)
				gap_q <= 8'(chain_pkg::IRQ_GAP_CYCLES);
			else if (gap_q != 8'h00)
				gap_q <= gap_q - 8'h01;
		end
	end

	// --------------------------------------------------------------------
	// Status view and interrupt
	// --------------------------------------------------------------------
	logic irq_q;
	wire gap_open = (gap_q == 8'h00);
	wire ta_w = (txq_n_q == 2'd0);
	wire ri_w = (rxq_n_q == 2'd0);
	wire tta_w = (txe_n_q != 2'd0) && gap_open;
	wire tri_w = (rxe_n_q != 2'd0) && gap_open;
	wire tma_w = chain_on ? (tta_w && txe_ack_q[0]) : last_ack_q;
	wire irq_chain = (tta_w && mask_q[chain_pkg::MASK_TX_BIT]) || (tri_w && mask_q[chain_pkg::MASK_RX_BIT]);
	wire irq_plain = (ta_w && mask_q[chain_pkg::MASK_TX_BIT]) || (ri_w && mask_q[chain_pkg::MASK_RX_BIT]);
	wire irq_d = chain_on ? irq_chain : irq_plain;

	// Status word for reads
	always_comb
	begin
		status_w = 32'h00000000;
		status_w[chain_pkg::STS_TA_BIT] = ta_w;
		status_w[chain_pkg::STS_TMA_BIT] = tma_w;
		status_w[chain_pkg::STS_TTA_BIT] = tta_w;
		status_w[chain_pkg::STS_TRI_BIT] = tri_w;
		status_w[chain_pkg::STS_RI_BIT] = ri_w;
		status_w[chain_pkg::STS_LONG_BIT] = rxe_long_q[0] && (rxe_n_q != 2'd0);
		status_w[chain_pkg::STS_CHAIN_BIT] = chain_on;
	end

	// Registered interrupt line
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_q <= 1'b0;
		else
			irq_q <= irq_d;
	end
	assign irq = irq_q;

endmodule

// ===== tb/packet_command_chaining_chk.sv
// Port assertions for the packet command chaining block
`timescale 1ns/1ps

module packet_command_chaining_chk #(
	parameter int PAGE_BITS = 3
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Transmit side
	input wire logic token_seen,
	input wire logic tx_complete,
	input wire logic tx_go,
	input wire logic tx_cancel,
	// Receive side
	input wire logic rx_frame_start,
	input wire logic rx_byte_valid,
	input wire logic [7:0] rx_byte,
	input wire logic rx_enabled,
	input wire logic ram_we,
	input wire logic [PAGE_BITS+7:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	// Interrupt
	input wire logic irq
);
	// ------------------------------------------------------------
	// Helper logic
	// ------------------------------------------------------------
	logic [4:0] low_q;
	logic [4:0] low_d;
	logic [PAGE_BITS-1:0] wpage;
	// Cycles since irq was last high, saturating so a long quiet spell never wraps
	assign low_d = irq ? 5'h00 : ((low_q == 5'h1F) ? low_q : low_q + 5'h01);
	assign wpage = ram_addr[PAGE_BITS+7:8];
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			low_q <= 5'h1F;
		else
			low_q <= low_d;
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	tx_go_cause_a: assert property (tx_go |-> $past(token_seen)) else $error("tx_go without token");
	tx_go_pulse_a: assert property (tx_go |=> !tx_go) else $error("tx_go longer than one cycle");
	tx_cancel_a: assert property (tx_cancel |-> !$past(tx_complete))
		else $error("cancel in completion cycle");
	ram_we_cause_a: assert property (ram_we |-> $past(rx_byte_valid) && ram_wdata == $past(rx_byte))
		else $error("ram write does not match byte");
	// A long packet runs on into the following page at offset 0
	ram_page_a: assert property (ram_we && $past(ram_we) |-> $stable(wpage) ||
		(ram_addr[7:0] == 8'h00 && wpage == $past(wpage) + 1'b1)) else $error("page moved in frame");
	ram_enable_a: assert property (!rx_enabled && !$past(rx_enabled) |-> !ram_we) else $error("write while off");
	rx_first_a: assert property (rx_enabled && rx_frame_start ##1 rx_byte_valid |=> ram_we && ram_addr[7:0] == 8'h00)
		else $error("first byte not at offset 0");
	rx_short_a: assert property (rx_enabled && rx_frame_start ##1 rx_byte_valid [*2] ##1
		(rx_byte_valid && rx_byte != 8'h00) ##1 rx_byte_valid |=> ram_addr[7:0] == $past(rx_byte, 2))
		else $error("short data offset wrong");
	irq_gap_a: assert property ($rose(irq) |-> low_q >= 5'h19) else $error("irq gap too short");
endmodule

bind packet_command_chaining packet_command_chaining_chk #(.PAGE_BITS(PAGE_BITS)) u_chk (.hclk(hclk),
	.hresetn(hresetn), .token_seen(token_seen), .tx_complete(tx_complete), .tx_go(tx_go), .tx_cancel(tx_cancel),
	.rx_frame_start(rx_frame_start), .rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_enabled(rx_enabled),
	.ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .irq(irq));

// ===== tb/core_model.sv
// Behavioural network core driving tokens, completions and frames
`timescale 1ns/1ps

module core_model (
	// Clock
	input wire logic hclk,
	// Transmit side
	input wire logic tx_go,
	input wire logic tx_cancel,
	output logic token_seen,
	output logic tx_complete,
	output logic tx_acked,
	// Receive side
	output logic rx_frame_start,
	output logic rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic rx_frame_end
);
	int tx_delay = 3;
	logic ack_next = 1'b1;
	logic drop;
	initial
	begin
		{token_seen, tx_complete, tx_acked, rx_frame_start, rx_byte_valid, rx_frame_end} = 6'h00;
		rx_byte = 8'h00;
	end
	// Finish each started transmission unless it is cancelled while in flight
	always @(posedge hclk)
	begin
		if (tx_go)
		begin
			drop = 1'b0;
			for (int i = 0; i < tx_delay; i++)
			begin
				@(posedge hclk);
				drop = drop | tx_cancel;
			end
			tx_complete <= !drop;
			tx_acked <= ack_next;
			@(posedge hclk);
			tx_complete <= 1'b0;
			tx_acked <= !ack_next;
		end
	end
	// One token pass
	task automatic token();
		@(posedge hclk);
		token_seen <= 1'b1;
		@(posedge hclk);
		token_seen <= 1'b0;
	endtask
	// Frame in wire order, end pulse with the last byte, line inverted once released
	task automatic frame(input logic [7:0] b[5]);
		@(posedge hclk);
		rx_frame_start <= 1'b1;
		foreach (b[i])
		begin
			@(posedge hclk);
			rx_frame_start <= 1'b0;
			rx_byte_valid <= 1'b1;
			rx_byte <= b[i];
		end
		rx_frame_end <= 1'b1;
		@(posedge hclk);
		rx_byte_valid <= 1'b0;
		rx_frame_end <= 1'b0;
		rx_byte <= ~rx_byte;
	endtask
endmodule

// ===== tb/packet_command_chaining_tb.sv
// Self-checking bench for the packet command chaining block
`timescale 1ns/1ps

module packet_command_chaining_tb;
	typedef struct packed
	{
		logic [2:0] pg;
		logic [7:0] b2;
		logic [7:0] b3;
		logic [7:0] o3;
		logic [7:0] o4;
		logic lng;
	} row_t;
	logic hclk, hresetn, hwrite, hreadyout, hresp, token_seen, tx_complete, tx_acked, tx_go, tx_cancel, irq;
	logic rx_frame_start, rx_byte_valid, rx_frame_end, rx_enabled, ram_we;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] tx_page;
	logic [7:0] rx_byte, ram_wdata;
	logic [10:0] ram_addr;
	logic [18:0] wq[$];
	int fail_count = 0, n_tests = 0, cyc = 0, go_cnt = 0, cancel_cnt = 0;
	// Receive table: page, count bytes, expected offsets of bytes 3 and 4, long flag
	row_t rows[3] = '{'{3'h1, 8'hFE, 8'h5A, 8'hFE, 8'hFF, 1'b0}, '{3'h6, 8'h00, 8'hFF, 8'h03, 8'hFF, 1'b1},
		'{3'h7, 8'h80, 8'h3C, 8'h80, 8'h81, 1'b0}};
	packet_command_chaining u_packet_command_chaining (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .token_seen(token_seen), .tx_complete(tx_complete),
		.tx_acked(tx_acked), .tx_go(tx_go), .tx_page(tx_page), .tx_cancel(tx_cancel), .rx_frame_start(rx_frame_start),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_frame_end(rx_frame_end), .rx_enabled(rx_enabled),
		.ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata), .irq(irq));
	core_model u_core_model (.hclk(hclk), .tx_go(tx_go), .tx_cancel(tx_cancel), .token_seen(token_seen),
		.tx_complete(tx_complete), .tx_acked(tx_acked), .rx_frame_start(rx_frame_start),
		.rx_byte_valid(rx_byte_valid), .rx_byte(rx_byte), .rx_frame_end(rx_frame_end));
	initial
	begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// Write capture, pulse counts and run limit
	always @(posedge hclk)
	begin
		cyc <= cyc + 1;
		if (ram_we) wq.push_back({ram_addr, ram_wdata});
		if (tx_go) go_cnt++;
		if (tx_cancel) cancel_cnt++;
		if (cyc == 6000)
		begin
			fail_count++;
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One AHB-Lite single word transfer, read data left in rd
	task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic cmd(input logic [3:0] c, input logic [2:0] p);
		rw(1'b1, chain_pkg::COMMAND_ADDR, {21'h0, p, 4'h0, c});
	endtask
	task automatic st(input logic [31:0] e);
		rw(1'b0, chain_pkg::STATUS_ADDR, 32'h0);
		chk(rd, e);
	endtask
	// Send one frame and compare every RAM write with page and offset
	task automatic frame_chk(input row_t r);
		logic [7:0] d[5];
		logic [7:0] o[5];
		d = '{8'h11, 8'h22, r.b2, r.b3, 8'hC3};
		o = '{8'h00, 8'h01, 8'h02, r.o3, r.o4};
		wq.delete();
		u_core_model.frame(d);
		repeat (2) @(posedge hclk);
		chk(wq.size(), 5);
		foreach (o[i]) chk({13'h0, wq[i]}, {13'h0, r.pg, o[i], d[i]});
	endtask
	initial
	begin
		{hresetn, hwrite, htrans, haddr, hwdata} = '0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rw(1'b0, chain_pkg::CONFIG_ADDR, 32'h0);
		chk(rd, 32'h0);
		st(32'h11);
		rw(1'b1, 8'h1C, 32'hFFFFFFFF);
		rw(1'b0, 8'h1C, 32'h0);
		chk(rd, 32'h0);
		rw(1'b1, chain_pkg::CONFIG_ADDR, 32'h48);
		rw(1'b1, chain_pkg::MASK_ADDR, 32'h3);
		st(32'h51);
		chk(irq, 1'b0);
		foreach (rows[i])
		begin
			cmd(chain_pkg::CMD_ENABLE_RX, rows[i].pg);
			st(32'h41);
			frame_chk(rows[i]);
			st(32'h59 | {26'h0, rows[i].lng, 5'h00});
			chk(irq, 1'b1);
			cmd(chain_pkg::CMD_CLEAR_RX, 3'h0);
			repeat (30) @(posedge hclk);
		end
		cmd(chain_pkg::CMD_ENABLE_TX, 3'h2);
		cmd(chain_pkg::CMD_ENABLE_TX, 3'h5);
		st(32'h50);
		chk(tx_page, 3'h2);
		u_core_model.token();
		repeat (8) @(posedge hclk);
		st(32'h56);
		chk(irq, 1'b1);
		chk(tx_page, 3'h5);
		u_core_model.ack_next = 1'b0;
		u_core_model.token();
		repeat (8) @(posedge hclk);
		st(32'h57);
		cmd(chain_pkg::CMD_CLEAR_TX, 3'h0);
		repeat (2) @(negedge hclk);
		chk(irq, 1'b0);
		repeat (30) @(posedge hclk);
		st(32'h55);
		chk(irq, 1'b1);
		cmd(chain_pkg::CMD_CLEAR_TX, 3'h0);
		repeat (30) @(posedge hclk);
		cmd(chain_pkg::CMD_CLEAR_TX, 3'h0);
		repeat (30) @(posedge hclk);
		st(32'h51);
		chk(go_cnt, 2);
		cmd(chain_pkg::CMD_ENABLE_TX, 3'h1);
		cmd(chain_pkg::CMD_ENABLE_TX, 3'h3);
		cmd(chain_pkg::CMD_ENABLE_TX, 3'h4);
		cmd(chain_pkg::CMD_DISABLE_TX, 3'h0);
		repeat (2) @(negedge hclk);
		chk(tx_page, 3'h3);
		cmd(chain_pkg::CMD_DISABLE_TX, 3'h0);
		st(32'h51);
		u_core_model.token();
		repeat (8) @(posedge hclk);
		chk(go_cnt, 2);
		u_core_model.tx_delay = 40;
		cmd(chain_pkg::CMD_ENABLE_TX, 3'h6);
		u_core_model.token();
		cmd(chain_pkg::CMD_DISABLE_TX, 3'h0);
		repeat (50) @(posedge hclk);
		chk(cancel_cnt, 1);
		st(32'h51);
		cmd(chain_pkg::CMD_ENABLE_RX, 3'h2);
		cmd(chain_pkg::CMD_ENABLE_RX, 3'h4);
		frame_chk('{3'h2, 8'hFE, 8'h5A, 8'hFE, 8'hFF, 1'b0});
		frame_chk('{3'h4, 8'hFE, 8'h5A, 8'hFE, 8'hFF, 1'b0});
		st(32'h59);
		cmd(chain_pkg::CMD_CLEAR_RX, 3'h0);
		repeat (30) @(posedge hclk);
		st(32'h59);
		cmd(chain_pkg::CMD_CLEAR_RX, 3'h0);
		repeat (30) @(posedge hclk);
		st(32'h51);
		cmd(chain_pkg::CMD_ENABLE_RX, 3'h3);
		cmd(chain_pkg::CMD_ENABLE_RX, 3'h5);
		cmd(chain_pkg::CMD_DISABLE_RX, 3'h0);
		frame_chk('{3'h5, 8'h80, 8'h3C, 8'h80, 8'h81, 1'b0});
		cmd(chain_pkg::CMD_CLEAR_RX, 3'h0);
		repeat (30) @(posedge hclk);
		wq.delete();
		u_core_model.frame('{8'h11, 8'h22, 8'hFE, 8'h5A, 8'hC3});
		repeat (2) @(posedge hclk);
		chk(wq.size(), 0);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		st(32'h11);
		chk(irq, 1'b0);
		// Non-chaining mode: the transmit mask gates the available level itself
		rw(1'b1, chain_pkg::MASK_ADDR, 32'h1);
		repeat (2) @(posedge hclk);
		chk(irq, 1'b1);
		cmd(chain_pkg::CMD_ENABLE_TX, 3'h1);
		st(32'h10);
		chk(irq, 1'b0);
		u_core_model.ack_next = 1'b1;
		u_core_model.token();
		repeat (50) @(posedge hclk);
		st(32'h17);
		chk(irq, 1'b1);
		close_out();
	end
endmodule
